// file: verilog/can_flag_pkg.sv
// Constants for the CAN interrupt flag and error state register block
// Assumes a plain register port with word addresses and 16-bit data
package can_flag_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned FLAG_W = 8;
  localparam int unsigned STATE_W = 6;

  // Register word addresses
  localparam logic [2:0] ADDR_FLAGS = 3'h0;
  localparam logic [2:0] ADDR_MASK = 3'h1;
  localparam logic [2:0] ADDR_PENDING = 3'h2;

  // Bit positions within can_interrupt_flags
  localparam int unsigned POS_TX_BUS_OFF = 13;
  localparam int unsigned POS_TX_BUS_PASSIVE = 12;
  localparam int unsigned POS_RX_BUS_PASSIVE = 11;
  localparam int unsigned POS_TX_WARNING = 10;
  localparam int unsigned POS_RX_WARNING = 9;
  localparam int unsigned POS_ANY_WARNING = 8;
  localparam int unsigned POS_INVALID_MSG = 7;
  localparam int unsigned POS_BUS_WAKEUP = 6;
  localparam int unsigned POS_ERROR_EVENT = 5;
  localparam int unsigned POS_FIFO_FULL = 3;
  localparam int unsigned POS_RX_OVERFLOW = 2;
  localparam int unsigned POS_RX_BUFFER = 1;
  localparam int unsigned POS_TX_BUFFER = 0;

  // Implemented sticky flag bits; bit 4 stays unimplemented
  localparam logic [7:0] FLAG_IMPL = 8'hef;

  // Values after reset
  localparam logic [15:0] RESET_FLAGS_REG = 16'h0000;
  localparam logic [15:0] RESET_MASK = 16'h0000;
  localparam logic [7:0] RESET_FLAGS = 8'h00;
  localparam logic [5:0] RESET_STATE = 6'h00;

endpackage

// file: verilog/level_rise_detect.sv
// Rising edge detector bank for error state levels
// Assumes levels already synchronous to clock
`timescale 1ns/1ps
module level_rise_detect #(
  parameter int unsigned WIDTH = 6
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  typedef struct packed {
    logic [WIDTH-1:0] prev;
  } rise_state_t;

  rise_state_t state;
  rise_state_t next_state;

  always_comb begin
    next_state.prev = level;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // One pulse per bit on entry into a state
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_rise
      assign rise[i] = level[i] & ~state.prev[i];
    end
  endgenerate

endmodule

// file: verilog/sticky_flag_bank.sv
// Bank of sticky flags, set by hardware, cleared by a clear request
// Assumes set and clear are one-cycle requests on clock
`timescale 1ns/1ps
module sticky_flag_bank #(
  parameter int unsigned WIDTH = 8,
  parameter logic [WIDTH-1:0] IMPL = '1
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clear,
  output logic [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } flag_state_t;

  flag_state_t state;
  flag_state_t next_state;

  // Set wins over a clear in the same cycle
  always_comb begin
    next_state.flags = ((state.flags & ~clear) | set) & IMPL;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags = state.flags;

endmodule

// file: verilog/can_interrupt_flag_status.sv
// CAN interrupt flag and error state status register with interrupt mask
// Assumes error state levels and event pulses come from the protocol
// engine, synchronous to clock; one-cycle register strobes
//
// Function
// [RQ1] Bit 13 reads 1 while the transmitter is bus-off, else 0.
// [RQ2] Bit 12 reads 1 while the transmitter is bus-passive, else 0.
// [RQ3] Bit 11 reads 1 while the receiver is bus-passive, else 0.
// [RQ4] Bit 10 reads 1 while the transmitter is in error warning.
// [RQ5] Bit 9 reads 1 while the receiver is in error warning.
// [RQ6] Bit 8 reads 1 while transmitter or receiver is in warning.
// [RQ7] Bit 7 is a sticky flag set by an invalid message on the bus.
// [RQ8] Bit 6 is a sticky flag set by wake-up activity on the bus.
// [RQ9] Bit 5 is a sticky flag set by the error states of bits 13 to 8.
// [RQ10] Bit 3 is a sticky flag set when the receive FIFO is almost full.
// [RQ11] Bit 2 is a sticky flag set by a receive buffer overflow.
// [RQ12] Bits 15, 14 and 4 read as zero and ignore writes.
// [RQ13] Flags clear only on a written zero; a written one leaves them.
// [RQ14] Bits 13 to 8 ignore writes and the whole register resets to 0.
// [RQ15] Bit 1 flags a received message, bit 0 a free transmit buffer.
`timescale 1ns/1ps
module can_interrupt_flag_status #(
  parameter int unsigned DATA_W = can_flag_pkg::DATA_W,
  parameter int unsigned ADDR_W = can_flag_pkg::ADDR_W
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [DATA_W-1:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [DATA_W-1:0] read_data,
  output logic interrupt,
  input wire logic tx_bus_off,
  input wire logic tx_bus_passive,
  input wire logic rx_bus_passive,
  input wire logic tx_warning,
  input wire logic rx_warning,
  input wire logic invalid_message,
  input wire logic bus_wakeup,
  input wire logic fifo_almost_full,
  input wire logic rx_overflow,
  input wire logic rx_buffer_received,
  input wire logic tx_buffer_available
);

  localparam int unsigned FW = can_flag_pkg::FLAG_W;
  localparam int unsigned SW = can_flag_pkg::STATE_W;

  typedef struct packed {
    logic [DATA_W-1:0] read_data;
    logic interrupt;
    logic [SW-1:0] error_state;
    logic [DATA_W-1:0] mask;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;

  logic [FW-1:0] flags;
  logic [FW-1:0] flag_set;
  logic [FW-1:0] flag_clear;
  logic [SW-1:0] state_rise;
  logic [DATA_W-1:0] flags_word;
  logic [DATA_W-1:0] pending_word;

  // Address match of a register access
  function automatic logic hits(
    input logic [ADDR_W-1:0] addr,
    input logic [2:0] target
  );
    hits = (addr == ADDR_W'(target));
  endfunction

  // Error states arranged as bits 13 down to 8
  function automatic logic [SW-1:0] pack_state(
    input logic bo,
    input logic tbp,
    input logic rbp,
    input logic tw,
    input logic rw
  );
    pack_state = {bo, tbp, rbp, tw, rw, tw | rw};
  endfunction

  level_rise_detect #(
    .WIDTH(SW)
  ) u_rise (
    .clock(clock),
    .reset_n(reset_n),
    .level(state.error_state),
    .rise(state_rise)
  );

  // Hardware event sources of the sticky flags
  always_comb begin
    flag_set = '0;
    flag_set[can_flag_pkg::POS_INVALID_MSG] = invalid_message; // [RQ7]
    flag_set[can_flag_pkg::POS_BUS_WAKEUP] = bus_wakeup; // [RQ8]
    flag_set[can_flag_pkg::POS_ERROR_EVENT] = |state_rise; // [RQ9]
    flag_set[can_flag_pkg::POS_FIFO_FULL] = fifo_almost_full; // [RQ10]
    flag_set[can_flag_pkg::POS_RX_OVERFLOW] = rx_overflow; // [RQ11]
    flag_set[can_flag_pkg::POS_RX_BUFFER] = rx_buffer_received; // [RQ15]
    flag_set[can_flag_pkg::POS_TX_BUFFER] = tx_buffer_available; // [RQ15]
  end

  // A written zero clears, a written one leaves the flag
  always_comb begin
    flag_clear = '0;
    if (write_strobe && hits(address, can_flag_pkg::ADDR_FLAGS)) begin
      flag_clear = ~write_data[FW-1:0]; // [RQ13]
    end
  end

  sticky_flag_bank #(
    .WIDTH(FW),
    .IMPL(can_flag_pkg::FLAG_IMPL)
  ) u_flags (
    .clock(clock),
    .reset_n(reset_n),
    .set(flag_set),
    .clear(flag_clear),
    .flags(flags)
  );

  // Register views
  always_comb begin
    flags_word = '0;
    flags_word[13:8] = state.error_state; // [RQ14]
    flags_word[FW-1:0] = flags & can_flag_pkg::FLAG_IMPL; // [RQ12]
    pending_word = flags_word & state.mask;
    pending_word[13:8] = '0;
  end

  always_comb begin
    next_state = state;
    // Error states follow the engine; writes never reach them
    next_state.error_state = pack_state(tx_bus_off, tx_bus_passive,
      rx_bus_passive, tx_warning, rx_warning); // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5] [RQ6]
    if (write_strobe && hits(address, can_flag_pkg::ADDR_MASK)) begin
      next_state.mask = write_data &
        {{(DATA_W-FW){1'b0}}, can_flag_pkg::FLAG_IMPL};
    end
    next_state.read_data = '0;
    if (read_strobe) begin
      if (hits(address, can_flag_pkg::ADDR_FLAGS)) begin
        next_state.read_data = flags_word;
      end else if (hits(address, can_flag_pkg::ADDR_MASK)) begin
        next_state.read_data = state.mask;
      end else if (hits(address, can_flag_pkg::ADDR_PENDING)) begin
        next_state.read_data = pending_word;
      end
    end
    next_state.interrupt = |pending_word[FW-1:0];
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state.read_data <= '0;
      state.interrupt <= 1'b0;
      state.error_state <= can_flag_pkg::RESET_STATE; // [RQ14]
      state.mask <= can_flag_pkg::RESET_MASK;
    end else begin
      state <= next_state;
    end
  end

  assign read_data = state.read_data;
  assign interrupt = state.interrupt;

endmodule

// file: dv/can_flag_asserts.sv
// Checker of the CAN flag register block at its ports
// Bound from the bench top; one clock, synchronous reset
`timescale 1ns/1ps
module can_flag_asserts (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [2:0] address,
  input wire logic [15:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic [15:0] read_data,
  input wire logic interrupt,
  input wire logic tx_bus_off,
  input wire logic tx_bus_passive,
  input wire logic rx_bus_passive,
  input wire logic tx_warning,
  input wire logic rx_warning,
  input wire logic invalid_message,
  input wire logic bus_wakeup,
  input wire logic fifo_almost_full,
  input wire logic rx_overflow,
  input wire logic rx_buffer_received,
  input wire logic tx_buffer_available
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire [4:0] lv = {tx_bus_off, tx_bus_passive, rx_bus_passive, tx_warning,
    rx_warning};
  wire [5:0] ev = {invalid_message, bus_wakeup, fifo_almost_full,
    rx_overflow, rx_buffer_received, tx_buffer_available};
  wire [5:0] fl = {read_data[7:6], read_data[3:0]};
  unimpl_zero_a: assert property (
    read_data[15:14] == 2'h0 && !read_data[4]) else $error("unused bits");
  idle_zero_a: assert property (
    !$past(read_strobe) || $past(address) > 3'h2 |-> read_data == 16'h0)
    else $error("stray read data");
  any_warn_a: assert property (
    read_data[8] == (read_data[10] | read_data[9])) else $error("warn or");
  state_view_a: assert property (
    $past(read_strobe) && $past(address) == 3'h0 && $past(lv, 2) == $past(lv)
    && $past(lv, 3) == $past(lv) |-> read_data[13:9] == $past(lv))
    else $error("state bits");
  event_set_a: assert property (
    $past(read_strobe) && $past(address) == 3'h0
    |-> (fl & $past(ev, 2)) == $past(ev, 2)) else $error("event flag");
  error_flag_a: assert property (
    $past(read_strobe) && $past(address) == 3'h0 && !$past(write_strobe, 2)
    && |($past(lv, 4) & ~$past(lv, 5)) |-> read_data[5])
    else $error("error flag");
  clear_only_a: assert property (
    $fell(interrupt) |-> $past(write_strobe) || $past(write_strobe, 2))
    else $error("flag lost");
  mask_off_a: assert property (
    write_strobe && address == 3'h1 && write_data == 16'h0 |-> ##2 !interrupt)
    else $error("masked interrupt");
endmodule

// file: dv/can_engine_model.sv
// Model of the protocol engine feeding error levels and events
// Bench sets requests; outputs change just after the clock edge
`timescale 1ns/1ps
module can_engine_model (
  input wire logic clock,
  input wire logic [4:0] level_req,
  input wire logic [5:0] event_req,
  output logic [4:0] levels,
  output logic [5:0] events
);
  always_ff @(posedge clock) begin
    levels <= level_req;
    events <= event_req;
  end
endmodule

// file: dv/can_interrupt_flag_status_tb.sv
// Bench of the CAN flag register block with a model engine
// Assumes design, checker and model files are compiled first
`timescale 1ns/1ps
module can_interrupt_flag_status_tb;
  logic clock = 1'h0, reset_n = 1'h0, write_strobe = 1'h0, read_strobe = 1'h0;
  logic [2:0] address = 3'h0;
  logic [15:0] write_data = 16'h0, read_data, w;
  logic interrupt;
  logic [4:0] lvr = 5'h0, lv;
  logic [5:0] evr = 6'h0, ev;
  logic [31:0] seed = 32'hb37e, r;
  int fail_count = 0, n_compared = 0;
  always #5 clock = ~clock;
  can_engine_model eng (.clock(clock), .level_req(lvr), .event_req(evr),
    .levels(lv), .events(ev));
  can_interrupt_flag_status dut (.clock(clock), .reset_n(reset_n),
    .address(address), .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data), .interrupt(interrupt),
    .tx_bus_off(lv[4]), .tx_bus_passive(lv[3]), .rx_bus_passive(lv[2]),
    .tx_warning(lv[1]), .rx_warning(lv[0]), .invalid_message(ev[5]),
    .bus_wakeup(ev[4]), .fifo_almost_full(ev[3]), .rx_overflow(ev[2]),
    .rx_buffer_received(ev[1]), .tx_buffer_available(ev[0]));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] fmap(input logic [5:0] e);
    return {8'h0, e[5:4], 2'h0, e[3:0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    write_strobe <= 1'h1;
    address <= a;
    write_data <= d;
    @(posedge clock);
    write_strobe <= 1'h0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clock);
    read_strobe <= 1'h1;
    address <= a;
    @(posedge clock);
    read_strobe <= 1'h0;
    #1 w = read_data;
  endtask
  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    summarize;
  end
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'h1;
    rd(3'h0);
    check(w, 16'h0);
    rd(3'h7);
    check(w, 16'h0);
    wr(3'h1, 16'hffff);
    rd(3'h1);
    check(w, 16'h00ef);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      r = (i < 2) ? (i ? 32'hffff0000 : 32'h0000ffff) : seed;
      @(posedge clock) lvr <= r[4:0];
      repeat (5) @(posedge clock);
      wr(3'h0, 16'h0);
      @(posedge clock) evr <= r[10:5];
      @(posedge clock) evr <= 6'h0;
      repeat (3) @(posedge clock);
      #1 check({15'h0, interrupt}, {15'h0, |r[10:5]});
      wr(3'h0, 16'hffff);
      rd(3'h0);
      check(w[15:8], {2'h0, r[4:0], r[1] | r[0]});
      check(w[7:0], fmap(r[10:5]));
      wr(3'h0, r[31:16]);
      rd(3'h0);
      check(w[7:0], fmap(r[10:5]) & r[31:16]);
      rd(3'h2);
      check(w, fmap(r[10:5]) & r[31:16] & 16'h00ef);
    end
    @(posedge clock) lvr <= 5'h0;
    repeat (5) @(posedge clock);
    wr(3'h0, 16'h0);
    @(posedge clock) lvr <= 5'h01;
    repeat (3) @(posedge clock);
    rd(3'h0);
    check(w, 16'h0320);
    @(posedge clock) evr <= 6'h20;
    @(posedge clock) evr <= 6'h0;
    wr(3'h1, 16'h0);
    repeat (2) @(posedge clock);
    #1 check({15'h0, interrupt}, 16'h0);
    rd(3'h0);
    check(w, 16'h03a0);
    summarize;
  end
endmodule
bind can_interrupt_flag_status can_flag_asserts chk (.*);
